// >>> lcdpst_timing.sv
// lcd panel signal timing: registers, refresh fetch, pixel engine, contrast pwm
`include "lcdpst_consts.svh"
module lcdpst_timing
  import lcdpst_pkg::*;
#(
  parameter int PWM_W = 8
) (
  // clocks and reset
  input logic clk_sys,
  input logic nrst,
  input logic clk_lcd,
  // register port
  input logic [7:0] regAddr,
  input logic [31:0] regWdata,
  input logic regWr,
  input logic regRd,
  output logic [31:0] regRdata,
  // refresh fetch master
  output lcdpst_dma_t dmaOut,
  input logic dmaAck,
  input logic [15:0] dmaData,
  // panel pins
  output logic [3:0] panelPixelData,
  output logic panelPinsOe_n,
  output logic panelPullDown,
  output logic pixelShiftClock,
  output logic lineLatchPulse,
  output logic frameStartMarker,
  output logic polarityAlternateToggle,
  // contrast pin
  output logic contrastPwmOut,
  output logic contrastOe_n,
  output logic contrastPullUp,
  // port inputs
  input logic [7:0] portCGpio,
  input logic portFBit0Gpio
);

  ////////////////////////////////////////////////////////////////////////
  logic [8:0] ctrl_q;
  logic [31:0] geom_q;
  logic [23:0] base_q;
  logic [3:0] acdPer_q;
  logic [PWM_W-1:0] duty_q;
  logic [31:0] regRdata_q;
  logic [8:0] gpioM_q, gpioS_q;
  logic [15:0] frames_q;
  lcdpst_cfg_t cfgSys;
  assign cfgSys = '{en: ctrl_q[`LPS_EN], wid: ctrl_q[`LPS_WID+1:`LPS_WID],
                    inv: ctrl_q[`LPS_INV], fpol: ctrl_q[`LPS_FPOL],
                    lpol: ctrl_q[`LPS_LPOL], cpol: ctrl_q[`LPS_CPOL]};

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      ctrl_q <= `LPS_CTRL_RST;
      geom_q <= `LPS_GEOM_RST;
      base_q <= 24'h000000;
      acdPer_q <= `LPS_ACD_RST;
      duty_q <= `LPS_DUTY_RST;
    end else if (regWr) begin
      unique case (regAddr)
        `LPS_REG_CTRL: ctrl_q <= regWdata[8:0];
        `LPS_REG_GEOM: geom_q <= regWdata;
        `LPS_REG_BASE: base_q <= regWdata[23:0];
        `LPS_REG_ACD: acdPer_q <= regWdata[3:0];
        `LPS_REG_DUTY: duty_q <= regWdata[PWM_W-1:0];
        default: ;
      endcase
    end
  end

  // port pins are asynchronous to clk_sys
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      gpioM_q <= 9'h000;
      gpioS_q <= 9'h000;
    end else begin
      gpioM_q <= {portFBit0Gpio, portCGpio};
      gpioS_q <= gpioM_q;
    end
  end

  logic acdM_q, acdS_q;
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      regRdata_q <= 32'h00000000;
    end else if (regRd) begin
      unique case (regAddr)
        `LPS_REG_CTRL: regRdata_q <= {23'h000000, ctrl_q};
        `LPS_REG_GEOM: regRdata_q <= geom_q;
        `LPS_REG_BASE: regRdata_q <= {8'h00, base_q};
        `LPS_REG_ACD: regRdata_q <= {28'h0000000, acdPer_q};
        `LPS_REG_DUTY: regRdata_q <= {{(32-PWM_W){1'b0}}, duty_q};
        `LPS_REG_STAT: regRdata_q <= {14'h0000, dmaOut.req, acdS_q, frames_q};
        `LPS_REG_GPIO: regRdata_q <= {23'h000000, gpioS_q};
        default: regRdata_q <= 32'h00000000;
      endcase
    end else begin
      regRdata_q <= 32'h00000000;
    end
  end
  assign regRdata = regRdata_q;

  ////////////////////////////////////////////////////////////////////////
  // contrast pwm, free running on clk_sys
  logic [PWM_W-1:0] pwmCnt_q;
  logic pwmOut_q, cOe_n_q, cPullUp_q;
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      pwmCnt_q <= '0;
      pwmOut_q <= 1'b0;
      cOe_n_q <= 1'b1;
      cPullUp_q <= 1'b1;
    end else begin
      pwmCnt_q <= pwmCnt_q + 1'b1;
      pwmOut_q <= ctrl_q[`LPS_CSEL] && (pwmCnt_q < duty_q);
      cOe_n_q <= ~ctrl_q[`LPS_CSEL];
      cPullUp_q <= ~ctrl_q[`LPS_CSEL];
    end
  end
  assign contrastPwmOut = pwmOut_q;
  assign contrastOe_n = cOe_n_q;
  assign contrastPullUp = cPullUp_q;

  a_contrast_gpio: assert property (@(posedge clk_sys) disable iff (!nrst)
    !ctrl_q[`LPS_CSEL] |=> contrastOe_n && contrastPullUp && !contrastPwmOut)
    else $error("contrast pin driven while deselected");

  ////////////////////////////////////////////////////////////////////////
  // refresh fetch: one word per request toggle from the link side
  logic reqT_q, first_q, ackT_q;
  logic reqM_q, reqS_q, reqD_q;
  logic [15:0] hold_q;
  lcdpst_dma_t dma_q;
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      reqM_q <= 1'b0;
      reqS_q <= 1'b0;
      reqD_q <= 1'b0;
    end else begin
      reqM_q <= reqT_q;
      reqS_q <= reqM_q;
      reqD_q <= reqS_q;
    end
  end

  // first_q is stable from its toggle until the word comes back
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      dma_q <= '0;
      hold_q <= 16'h0000;
      ackT_q <= 1'b0;
    end else if (dma_q.req && dmaAck) begin
      dma_q.req <= 1'b0;
      dma_q.addr <= dma_q.addr + `LPS_ADDR_STEP;
      hold_q <= dmaData;
      ackT_q <= ~ackT_q;
    end else if (reqS_q ^ reqD_q) begin
      dma_q.req <= 1'b1;
      dma_q.addr <= first_q ? base_q : dma_q.addr;
    end
  end
  assign dmaOut = dma_q;

  a_dma_hold: assert property (@(posedge clk_sys) disable iff (!nrst)
    dmaOut.req && !dmaAck |=> dmaOut.req && $stable(dmaOut.addr))
    else $error("fetch request dropped or address moved before ack");

  ////////////////////////////////////////////////////////////////////////
  // link domain reset release and crossings in
  logic rstM_q, lrst_n_q;
  always_ff @(posedge clk_lcd or negedge nrst) begin
    if (!nrst) begin
      rstM_q <= 1'b0;
      lrst_n_q <= 1'b0;
    end else begin
      rstM_q <= 1'b1;
      lrst_n_q <= rstM_q;
    end
  end

  logic enM_q, enS_q, pselM_q, pselS_q, ackM_q, ackS_q, ackD_q;
  logic [2:0] polM_q, polS_q;
  always_ff @(posedge clk_lcd or negedge lrst_n_q) begin
    if (!lrst_n_q) begin
      enM_q <= 1'b0;
      enS_q <= 1'b0;
      polM_q <= 3'h7;
      polS_q <= 3'h7;
      pselM_q <= 1'b0;
      pselS_q <= 1'b0;
      ackM_q <= 1'b0;
      ackS_q <= 1'b0;
      ackD_q <= 1'b0;
    end else begin
      enM_q <= ctrl_q[`LPS_EN];
      enS_q <= enM_q;
      polM_q <= {ctrl_q[`LPS_FPOL], ctrl_q[`LPS_LPOL], ctrl_q[`LPS_CPOL]};
      polS_q <= polM_q;
      pselM_q <= ctrl_q[`LPS_PSEL];
      pselS_q <= pselM_q;
      ackM_q <= ackT_q;
      ackS_q <= ackM_q;
      ackD_q <= ackS_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // pixel engine
  lcdpst_state_t st_q;
  lcdpst_cfg_t cfgL_q;
  logic [15:0] pplL_q, linesL_q, pixCnt_q, lineCnt_q, word_q;
  logic [4:0] bitsLeft_q, latchCnt_q, wbits;
  logic [3:0] acdL_q;
  logic phase_q, lineEnd, latchStart, latchEnd, lastLine;

  // lanes per shift from width code
  always_comb begin
    unique case (cfgL_q.wid)
      2'b00: wbits = 5'h01;
      2'b01: wbits = 5'h02;
      default: wbits = 5'h04;
    endcase
  end
  assign lineEnd = ({1'b0, pixCnt_q} + {12'h000, wbits}) >= {1'b0, pplL_q};
  assign latchStart = (st_q == ST_SHIFT) && phase_q && lineEnd;
  assign latchEnd = (st_q == ST_LATCH) && (latchCnt_q == 5'(`LPS_LATCH_CYC - 1));
  assign lastLine = (lineCnt_q == linesL_q - 16'h0001);

  // config is read only while the engine idles, long after its write
  always_ff @(posedge clk_lcd or negedge lrst_n_q) begin
    if (!lrst_n_q) begin
      st_q <= ST_IDLE;
      cfgL_q <= 7'h07;
      acdL_q <= 4'h0;
      pplL_q <= 16'h0000;
      linesL_q <= 16'h0000;
      pixCnt_q <= 16'h0000;
      lineCnt_q <= 16'h0000;
      word_q <= 16'h0000;
      bitsLeft_q <= 5'h00;
      latchCnt_q <= 5'h00;
      phase_q <= 1'b0;
      reqT_q <= 1'b0;
      first_q <= 1'b0;
    end else begin
      unique case (st_q)
        ST_IDLE: begin
          // idle pins follow the polarities, so enabling makes no false edge
          cfgL_q.fpol <= polS_q[2];
          cfgL_q.lpol <= polS_q[1];
          cfgL_q.cpol <= polS_q[0];
          if (enS_q) begin
            cfgL_q <= cfgSys;
            acdL_q <= acdPer_q;
            pplL_q <= geom_q[15:0];
            linesL_q <= geom_q[31:16];
            pixCnt_q <= 16'h0000;
            lineCnt_q <= 16'h0000;
            first_q <= 1'b1;
            reqT_q <= ~reqT_q;
            st_q <= ST_FETCH;
          end
        end
        ST_FETCH: begin
          if (ackS_q ^ ackD_q) begin
            word_q <= hold_q;
            bitsLeft_q <= `LPS_WORD_BITS;
            phase_q <= 1'b0;
            st_q <= ST_SHIFT;
          end
        end
        ST_SHIFT: begin
          phase_q <= ~phase_q;
          if (phase_q) begin
            // oldest pixel leaves from the top
            word_q <= word_q << wbits;
            bitsLeft_q <= bitsLeft_q - wbits;
            pixCnt_q <= pixCnt_q + {11'h000, wbits};
            if (lineEnd) begin
              latchCnt_q <= 5'h00;
              st_q <= ST_LATCH;
            end else if (bitsLeft_q == wbits) begin
              first_q <= 1'b0;
              reqT_q <= ~reqT_q;
              st_q <= ST_FETCH;
            end
          end
        end
        ST_LATCH: begin
          // hold for eight pixel clock periods
          latchCnt_q <= latchCnt_q + 5'h01;
          if (latchEnd) begin
            pixCnt_q <= 16'h0000;
            lineCnt_q <= lastLine ? 16'h0000 : lineCnt_q + 16'h0001;
            if (!enS_q) begin
              st_q <= ST_IDLE;
            end else begin
              first_q <= lastLine;
              reqT_q <= ~reqT_q;
              st_q <= ST_FETCH;
            end
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // frame marker, frame count and polarity toggle
  logic flmAct_q, acd_q, frmT_q;
  logic [3:0] frmCnt_q;
  always_ff @(posedge clk_lcd or negedge lrst_n_q) begin
    if (!lrst_n_q) begin
      flmAct_q <= 1'b0;
      acd_q <= 1'b0;
      frmT_q <= 1'b0;
      frmCnt_q <= 4'h0;
    end else if (st_q == ST_IDLE) begin
      flmAct_q <= 1'b0;
      frmCnt_q <= 4'h0;
    end else if (latchStart) begin
      // marker ends at the next line pulse
      flmAct_q <= 1'b0;
    end else if (latchEnd && lineCnt_q == 16'h0000) begin
      // marker starts after the first pulse
      flmAct_q <= 1'b1;
      frmT_q <= ~frmT_q;
      if (frmCnt_q == acdL_q) begin
        frmCnt_q <= 4'h0;
        // period of acd register plus one
        acd_q <= ~acd_q;
      end else begin
        frmCnt_q <= frmCnt_q + 4'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // registered pin drivers
  logic [3:0] pd_q;
  logic sclk_q, lp_q, flm_q, acdOut_q, pinsOe_n_q, pullDn_q;
  always_ff @(posedge clk_lcd or negedge lrst_n_q) begin
    if (!lrst_n_q) begin
      sclk_q <= 1'b0;
      lp_q <= 1'b0;
      flm_q <= 1'b0;
      acdOut_q <= 1'b0;
      pinsOe_n_q <= 1'b1;
      pullDn_q <= 1'b1;
    end else begin
      // active on the second half of each pixel
      sclk_q <= ~(((st_q == ST_SHIFT) && phase_q) ^ cfgL_q.cpol);
      lp_q <= ~((st_q == ST_LATCH) ^ cfgL_q.lpol);
      flm_q <= ~(flmAct_q ^ cfgL_q.fpol);
      acdOut_q <= acd_q;
      pinsOe_n_q <= ~pselS_q;
      pullDn_q <= ~pselS_q;
    end
  end

  for (genvar g = 0; g < 4; g++) begin : gLane
    always_ff @(posedge clk_lcd or negedge lrst_n_q) begin
      if (!lrst_n_q) begin
        pd_q[g] <= 1'b0;
      end else begin
        pd_q[g] <= pselS_q && (st_q == ST_SHIFT) && (5'(g) < wbits) &&
                   (word_q[15-g] ^ cfgL_q.inv);
      end
    end
  end

  assign panelPixelData = pd_q;
  assign panelPinsOe_n = pinsOe_n_q;
  assign panelPullDown = pullDn_q;
  assign pixelShiftClock = sclk_q;
  assign lineLatchPulse = lp_q;
  assign frameStartMarker = flm_q;
  assign polarityAlternateToggle = acdOut_q;

  ////////////////////////////////////////////////////////////////////////
  // crossings back to clk_sys
  logic frmM_q, frmS_q, frmD_q;
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      frmM_q <= 1'b0;
      frmS_q <= 1'b0;
      frmD_q <= 1'b0;
      acdM_q <= 1'b0;
      acdS_q <= 1'b0;
      frames_q <= 16'h0000;
    end else begin
      frmM_q <= frmT_q;
      frmS_q <= frmM_q;
      frmD_q <= frmS_q;
      acdM_q <= acd_q;
      acdS_q <= acdM_q;
      if (frmS_q ^ frmD_q) begin
        frames_q <= frames_q + 16'h0001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  a_latch_length: assert property (@(posedge clk_lcd) disable iff (!lrst_n_q)
    $rose(st_q == ST_LATCH) |-> ##15 (st_q == ST_LATCH) ##1 (st_q != ST_LATCH))
    else $error("line pulse not sixteen link cycles long");
  a_latch_level: assert property (@(posedge clk_lcd) disable iff (!lrst_n_q)
    ##1 lineLatchPulse == ($past(st_q == ST_LATCH) ~^ $past(cfgL_q.lpol)))
    else $error("line pulse level wrong for polarity");
  a_marker_rise: assert property (@(posedge clk_lcd) disable iff (!lrst_n_q)
    $rose(flmAct_q) |-> $past(latchEnd) && $past(lineCnt_q) == 16'h0000)
    else $error("marker rose outside first line pulse end");
  a_marker_fall: assert property (@(posedge clk_lcd) disable iff (!lrst_n_q)
    flmAct_q && latchStart |=> !flmAct_q ##1 flm_q == ~cfgL_q.fpol)
    else $error("marker not cleared at next line pulse");
  a_clock_idle: assert property (@(posedge clk_lcd) disable iff (!lrst_n_q)
    st_q == ST_LATCH |=> sclk_q == ~cfgL_q.cpol)
    else $error("shift clock active during line pulse");
  a_lane_width: assert property (@(posedge clk_lcd) disable iff (!lrst_n_q)
    cfgL_q.wid == 2'b00 |=> panelPixelData[3:1] == 3'b000)
    else $error("unused lanes driven in one-bit mode");
  a_pins_gpio: assert property (@(posedge clk_lcd) disable iff (!lrst_n_q)
    !pselS_q |=> panelPinsOe_n && panelPullDown && panelPixelData == 4'h0)
    else $error("panel pins driven while deselected");
  a_acd_cause: assert property (@(posedge clk_lcd) disable iff (!lrst_n_q)
    $changed(acd_q) |-> $past(latchEnd) && $past(frmCnt_q) == $past(acdL_q))
    else $error("polarity toggled away from frame period");

endmodule

// >>> lcdpst_consts.svh
// register map, field positions, reset values and timing counts
// Functional notes
// - Data bus runs one, two or four lanes wide as programmed.
// - A control bit inverts every pixel value before it is driven.
// - The first pixel of the panel goes out on data lane zero.
// - Frame marker rises after the first line pulse, falls at the next.
// - Frame marker active level is programmable high or low.
// - Line pulse follows each full line and lasts eight pixel clocks.
// - Line pulse active level is programmable high or low.
// - Pixel data is synchronised to a shift clock of selectable polarity.
// - Polarity toggle output flips every 1 to 16 frames, programmable.
// - Contrast output comes from a pulse-width modulator in the block.
// - After reset the data pins are pulled-down inputs until selected.
// - After reset the contrast pin is a pulled-up input until selected.
// - Refresh words are fetched from memory by the block as bus master.
`ifndef LCDPST_CONSTS_SVH
`define LCDPST_CONSTS_SVH
`define LPS_REG_CTRL 8'h00
`define LPS_REG_GEOM 8'h04
`define LPS_REG_BASE 8'h08
`define LPS_REG_ACD 8'h0C
`define LPS_REG_DUTY 8'h10
`define LPS_REG_STAT 8'h14
`define LPS_REG_GPIO 8'h18
`define LPS_EN 0
`define LPS_WID 1
`define LPS_INV 3
`define LPS_FPOL 4
`define LPS_LPOL 5
`define LPS_CPOL 6
`define LPS_PSEL 7
`define LPS_CSEL 8
`define LPS_CTRL_RST 9'h070
`define LPS_GEOM_RST 32'h00F0_0140
`define LPS_ACD_RST 4'h0
`define LPS_DUTY_RST 8'h80
`define LPS_LATCH_PCLK 8
`define LPS_LATCH_CYC (`LPS_LATCH_PCLK * 2)
`define LPS_WORD_BITS 5'h10
`define LPS_ADDR_STEP 24'h000002
`endif

// >>> lcdpst_pkg.sv
// types shared by the lcd panel timing block
package lcdpst_pkg;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_FETCH = 2'b01,
    ST_SHIFT = 2'b10,
    ST_LATCH = 2'b11
  } lcdpst_state_t;
  typedef struct packed {
    logic en;
    logic [1:0] wid;
    logic inv;
    logic fpol;
    logic lpol;
    logic cpol;
  } lcdpst_cfg_t;
  typedef struct packed {
    logic req;
    logic [23:0] addr;
  } lcdpst_dma_t;
endpackage

// >>> lcdpst_panel_model.sv
// passive panel model: rebuilds pixel words, times line pulses, counts frames
module lcdpst_panel_model (
  // link clock and bench control
  input wire logic clk_lcd,
  input wire logic nrst,
  input wire logic armed,
  input wire logic [2:0] lanes,
  input wire logic [2:0] pol,
  // panel pins
  input wire logic [3:0] pixData,
  input wire logic shiftClk,
  input wire logic latchPulse,
  input wire logic frameMark,
  input wire logic toggleIn,
  // observations
  output logic [15:0] lastWord,
  output int pulseLen,
  output int pulses,
  output int frames,
  output int toggles
);
  timeunit 1ns;
  timeprecision 100ps;
  logic clkQ, lpQ, fmQ, tgQ;
  int run;
  ////////////////////////////////////////
  // lane 0 carries the earliest pixel of each group
  function automatic logic [15:0] shiftIn(logic [15:0] w, logic [3:0] d, logic [2:0] n);
    for (int i = 0; i < n; i++)
      w = {w[14:0], d[i]};
    return w;
  endfunction
  ////////////////////////////////////////
  // unarmed, edges are only tracked so that arming never sees a false edge
  always @(posedge clk_lcd or negedge nrst) begin
    if (!nrst) begin
      lastWord <= 16'h0000;
      pulseLen <= 0;
      pulses <= 0;
      frames <= 0;
      toggles <= 0;
      run <= 0;
    end else if (armed) begin
      if (shiftClk == pol[2] && clkQ != pol[2])
        lastWord <= shiftIn(lastWord, pixData, lanes);
      if (latchPulse == pol[1])
        run <= run + 1;
      if (latchPulse != pol[1] && lpQ == pol[1]) begin
        pulseLen <= run;
        pulses <= pulses + 1;
        run <= 0;
      end
      if (frameMark == pol[0] && fmQ != pol[0])
        frames <= frames + 1;
      if (toggleIn != tgQ)
        toggles <= toggles + 1;
    end
    clkQ <= shiftClk;
    lpQ <= latchPulse;
    fmQ <= frameMark;
    tgQ <= toggleIn;
  end
endmodule

// >>> testbench.sv
// self-checking bench for the lcd panel timing block
`include "lcdpst_consts.svh"
module testbench import lcdpst_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_sys, nrst, clk_lcd, regWr, regRd, dmaAck, armed;
  logic [7:0] regAddr, portCGpio;
  logic [31:0] regWdata, regRdata;
  lcdpst_dma_t dmaOut;
  logic [15:0] dmaData, memWord, lastWord;
  logic [3:0] panelPixelData;
  logic panelPinsOe_n, panelPullDown, pixelShiftClock, lineLatchPulse, frameStartMarker;
  logic polarityAlternateToggle, contrastPwmOut, contrastOe_n, contrastPullUp, portFBit0Gpio;
  logic [2:0] lanes, pol;
  logic [1:0] ackDly;
  logic [23:0] addrQ[$];
  int pulseLen, pulses, frames, toggles, fail_count, n_checks;
  ////////////////////////////////////////
  lcdpst_timing u_dut (
    .clk_sys(clk_sys), .nrst(nrst), .clk_lcd(clk_lcd),
    .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
    .regRdata(regRdata), .dmaOut(dmaOut), .dmaAck(dmaAck), .dmaData(dmaData),
    .panelPixelData(panelPixelData), .panelPinsOe_n(panelPinsOe_n),
    .panelPullDown(panelPullDown), .pixelShiftClock(pixelShiftClock),
    .lineLatchPulse(lineLatchPulse), .frameStartMarker(frameStartMarker),
    .polarityAlternateToggle(polarityAlternateToggle), .contrastPwmOut(contrastPwmOut),
    .contrastOe_n(contrastOe_n), .contrastPullUp(contrastPullUp),
    .portCGpio(portCGpio), .portFBit0Gpio(portFBit0Gpio)
  );
  lcdpst_panel_model u_panel (
    .clk_lcd(clk_lcd), .nrst(nrst), .armed(armed), .lanes(lanes), .pol(pol),
    .pixData(panelPixelData), .shiftClk(pixelShiftClock), .latchPulse(lineLatchPulse),
    .frameMark(frameStartMarker), .toggleIn(polarityAlternateToggle),
    .lastWord(lastWord), .pulseLen(pulseLen), .pulses(pulses), .frames(frames),
    .toggles(toggles)
  );
  ////////////////////////////////////////
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  initial begin
    clk_lcd = 1'b0;
    #1.7;
    forever #3 clk_lcd = ~clk_lcd;
  end
  // refresh memory answers late on purpose; its data bus carries the inverted word between words
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      dmaAck <= 1'b0;
      ackDly <= 2'h0;
      addrQ.delete();
    end else if (dmaAck) begin
      dmaAck <= 1'b0;
      dmaData <= ~memWord;
    end else if (dmaOut.req && ackDly == 2'h2) begin
      dmaAck <= 1'b1;
      dmaData <= memWord;
      addrQ.push_back(dmaOut.addr);
      ackDly <= 2'h0;
    end else if (dmaOut.req)
      ackDly <= ackDly + 2'h1;
  end
  ////////////////////////////////////////
  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    regWr <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge clk_sys);
    regWr <= 1'b0;
  endtask
  task automatic reg_read_check(input string name, input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk_sys);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge clk_sys);
    regRd <= 1'b0;
    #1;
    check(name, exp, regRdata);
  endtask
  task automatic do_reset;
    @(posedge clk_sys);
    nrst <= 1'b0;
    armed <= 1'b0;
    repeat (8) @(posedge clk_sys);
    nrst <= 1'b1;
    repeat (4) @(posedge clk_sys);
    #1;
  endtask
  task automatic report_and_stop;
    if (fail_count == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  ////////////////////////////////////////
  task automatic t_reset_state;
    do_reset;
    portCGpio <= 8'hA5;
    portFBit0Gpio <= 1'b1;
    check("port c oe_n", 32'h1, panelPinsOe_n);
    check("port c pull-down", 32'h1, panelPullDown);
    check("contrast oe_n", 32'h1, contrastOe_n);
    check("contrast pull-up", 32'h1, contrastPullUp);
    reg_read_check("ctrl", `LPS_REG_CTRL, `LPS_CTRL_RST);
    reg_read_check("geom", `LPS_REG_GEOM, `LPS_GEOM_RST);
    reg_read_check("acd", `LPS_REG_ACD, `LPS_ACD_RST);
    reg_read_check("duty", `LPS_REG_DUTY, `LPS_DUTY_RST);
    reg_write(8'h1C, 32'hFFFF_FFFF);
    reg_read_check("unmapped", 8'h1C, 32'h0);
    reg_read_check("ctrl after stray write", `LPS_REG_CTRL, `LPS_CTRL_RST);
    reg_read_check("gpio", `LPS_REG_GPIO, 32'h0000_01A5);
  endtask
  // two lines of sixteen pixels, so one word per line and two per frame
  task automatic run_panel(input logic [8:0] ctrl, input logic [3:0] acd, input logic [15:0] w);
    do_reset;
    memWord <= w;
    lanes <= ctrl[2] ? 3'h4 : (ctrl[1] ? 3'h2 : 3'h1);
    pol <= ctrl[6:4];
    reg_write(`LPS_REG_GEOM, 32'h0002_0010);
    reg_write(`LPS_REG_BASE, 32'h0000_1000);
    reg_write(`LPS_REG_ACD, {28'h0, acd});
    reg_write(`LPS_REG_CTRL, {23'h0, ctrl[8:1], 1'b0});
    repeat (10) @(posedge clk_sys);
    armed <= 1'b1;
    reg_write(`LPS_REG_CTRL, {23'h0, ctrl});
    repeat (2000) @(posedge clk_sys);
    reg_write(`LPS_REG_CTRL, {23'h0, ctrl[8:1], 1'b0});
    repeat (300) @(posedge clk_sys);
    #1;
    check("pin oe_n", 32'h0, panelPinsOe_n);
    check("pin pull-down", 32'h0, panelPullDown);
    check("line word", {16'h0, ctrl[3] ? ~w : w}, lastWord);
    check("line pulse length", 32'h10, pulseLen);
    check("enough lines", 32'h1, pulses > 8);
    check("frames", (pulses + 1) / 2, frames);
    check("toggles", frames / (acd + 1), toggles);
    check("first fetch", 32'h1000, addrQ[0]);
    check("second fetch", 32'h1002, addrQ[1]);
    check("next frame fetch", 32'h1000, addrQ[2]);
    reg_read_check("stat", `LPS_REG_STAT, {15'h0000, toggles[0], frames[15:0]});
  endtask
  task automatic t_four_lanes;
    run_panel(9'h0F5, 4'h0, 16'h1E2D);
  endtask
  task automatic t_one_lane_inverted;
    run_panel(9'h089, 4'h1, 16'hC35A);
  endtask
  task automatic t_two_lanes;
    run_panel(9'h0F3, 4'h2, 16'h8421);
  endtask
  task automatic t_contrast;
    int hi;
    do_reset;
    reg_write(`LPS_REG_DUTY, 32'h0000_0040);
    reg_write(`LPS_REG_CTRL, 32'h0000_0170);
    repeat (4) @(posedge clk_sys);
    #1;
    check("contrast oe_n", 32'h0, contrastOe_n);
    check("contrast pull-up off", 32'h0, contrastPullUp);
    hi = 0;
    repeat (256) begin
      @(posedge clk_sys);
      #1;
      if (contrastPwmOut === 1'b1)
        hi++;
    end
    check("contrast high count", 32'h40, hi);
  endtask
  ////////////////////////////////////////
  initial begin
    nrst = 1'b0;
    regWr = 1'b0;
    regRd = 1'b0;
    regAddr = 8'h00;
    regWdata = 32'h0;
    dmaAck = 1'b0;
    dmaData = 16'h0000;
    memWord = 16'h0000;
    portCGpio = 8'h00;
    portFBit0Gpio = 1'b0;
    armed = 1'b0;
    lanes = 3'h1;
    pol = 3'h7;
    fail_count = 0;
    n_checks = 0;
    t_reset_state;
    t_four_lanes;
    t_one_lane_inverted;
    t_two_lanes;
    t_contrast;
    report_and_stop;
  end
  // runs should end near 73 us; a hang is cut off well after that
  initial begin
    #200us;
    fail_count++;
    report_and_stop;
  end
endmodule
